/* File: psl_cfg.svh */
`ifndef PSL_CFG_SVH
`define PSL_CFG_SVH
// ***********************************
// register map, byte addresses
// ***********************************
`define PSL_REG_CTRL 4'h0
`define PSL_REG_SLOT 4'h4
`define PSL_REG_DATA 4'h8
`define PSL_REG_STAT 4'hC
`define PSL_CTRL_BLANK 0
`define PSL_CTRL_CRC 1
`define PSL_CTRL_LEN10 2
`define PSL_CTRL_PD 3
`define PSL_CTRL_BAUD 4
`define PSL_CTRL_RST 32'h0000_0000
`define PSL_SLOT_RST 32'h0000_0800
`define PSL_DATA_RST 32'h0000_0000
// ***********************************
// timing, in nanoseconds unless named
// ***********************************
`define PSL_CLK_NS 25
`define PSL_BIT125_NS 8000
`define PSL_BIT190_NS 5250
`define PSL_QUAL_NS 3000
`define PSL_SYNC_MIN_NS 2000
`define PSL_OFF500_US 500
`define PSL_FILT_RST_NS 4000
`define PSL_PD_DLY_NS 9000
`define PSL_PD_ON_NS 10000
`endif

/* File: psl_frame_build.sv */
module psl_frame_build
(
    input wire logic sys_clk,
    input wire logic reset,
    psl_tx_if.builder txi
);
    import psl_pkg::*;

    // crc over data lsb first plus three zeros, seed all ones;
    // long-division form, so the appended zeros flush the remainder out
    function automatic logic [2:0] crc3(input logic [9:0] w, input logic l10);
        logic [2:0] c;
        logic fb;
        logic din;
        c = 3'h7;
        for (int i = 0; i < 13; i++)
        begin
            if (i < (l10 ? 13 : 11))
            begin
                din = (i < (l10 ? 10 : 8)) ? w[i[3:0]] : 1'b0;
                fb = c[2];
                c = {c[1], c[0] ^ fb, din ^ fb};
            end
        end
        return c;
    endfunction

    logic [2:0] ck;

    // check bits of the word on offer, taken only at load
    assign ck = crc3(txi.word, txi.len10);

    // latch one frame per load, start bits excluded from the check
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            txi.frame <= '0;
            txi.nbits <= 4'h0;
            txi.start <= 1'b0;
        end
        else
        begin
            txi.start <= txi.load;
            if (txi.load)
            begin
                if (txi.len10)
                    txi.frame <= txi.crc_sel ? {ck[0], ck[1], ck[2], txi.word, 2'b00}
                        : {2'b00, ^txi.word, txi.word, 2'b00};
                else
                    txi.frame <= txi.crc_sel ? {2'b00, ck[0], ck[1], ck[2], txi.word[7:0], 2'b00}
                        : {4'h0, ^txi.word[7:0], txi.word[7:0], 2'b00};
                txi.nbits <= 4'(2 + (txi.len10 ? 10 : 8) + (txi.crc_sel ? 3 : 1));
            end
        end
    end
endmodule // psl_frame_build

/* File: psl_link.sv */
// Operation
// - all device data goes out as drawn current, never a driven voltage
// - comparator feeds a counter sampled at half the oscillator rate
// - after fixed time, pulse valid only if count exceeds minimum width
// - all response timers start at the first comparator trip
// - valid sync raises valid flag and enables the responses timed from the trip
// - after valid sync, counter cleared and held off for blanking time
// - blank select zero uses the fixed short blanking time
// - blank select one: slot delay plus frame length in bit times
// - after valid sync the sync filter is held in reset for a while
// - failed qualification resets timers and re-arms on next sample
// - frame starts after the configured slot delay
// - optional pulldown sinks current after a delay for a set time
// - between frames the current rests at quiescent level
// - zero is a mid-bit current rise, one a mid-bit fall
// - every bit has a mid edge, equal neighbours add a boundary edge
// - frame is two start bits, 8 or 10 data bits, then check bits
// - data word goes out least significant bit first
// - a control bit chooses parity bit or 3-bit crc
// - parity makes the count of ones in the message even
// - crc uses x^3+x+1 seeded with all ones
// - crc takes data lsb first then three zeros, no start bits
`include "psl_cfg.svh"
module psl_link
#(
    parameter int OFF500_CYC = `PSL_OFF500_US * 1000 / `PSL_CLK_NS,
    parameter int QUAL_NS = `PSL_QUAL_NS,
    parameter int SYNC_MIN_NS = `PSL_SYNC_MIN_NS,
    parameter int FILT_RST_NS = `PSL_FILT_RST_NS,
    parameter int PD_DLY_NS = `PSL_PD_DLY_NS,
    parameter int PD_ON_NS = `PSL_PD_ON_NS
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sync_comp_in,
    output logic modulation_current,
    output logic sync_valid,
    output logic sync_filter_reset
);
    import psl_pkg::*;

    // ***********************************
    // timing counts
    // ***********************************
    localparam int SAMP_NS = 2 * `PSL_CLK_NS;
    localparam int QUAL_CYC = (QUAL_NS + `PSL_CLK_NS - 1) / `PSL_CLK_NS;
    localparam int MIN_CNT = (SYNC_MIN_NS + SAMP_NS - 1) / SAMP_NS;
    localparam int FILT_CYC = (FILT_RST_NS + `PSL_CLK_NS - 1) / `PSL_CLK_NS;
    localparam int PD_DLY_CYC = (PD_DLY_NS + `PSL_CLK_NS - 1) / `PSL_CLK_NS;
    localparam int PD_ON_CYC = PD_ON_NS / `PSL_CLK_NS;
    localparam int HALF125 = `PSL_BIT125_NS / `PSL_CLK_NS / 2;
    localparam int HALF190 = `PSL_BIT190_NS / `PSL_CLK_NS / 2;
    localparam logic [17:0] REF_MAX = 18'h3FFFF;

    if (QUAL_CYC < 2 || MIN_CNT < 1 || MIN_CNT > 254 || PD_ON_CYC < 1 || OFF500_CYC < QUAL_CYC
        || OFF500_CYC > 200000)
        $error("psl_link: timing parameters out of range");

    // frame length in bits for the chosen word and check
    function automatic logic [3:0] frame_bits(input logic l10, input logic crc);
        return 4'(2 + (l10 ? 10 : 8) + (crc ? 3 : 1));
    endfunction

    // byte-lane merge of a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // ***********************************
    // register slave
    // ***********************************
    logic [31:0] ctrl;
    logic [31:0] slot;
    logic [31:0] data;
    logic ack;
    logic [15:0] sync_count;
    logic tx_busy;
    logic tx_level;
    logic pd_on;
    psl_sd_state_t sd;
    logic blank_sel;
    logic crc_sel;
    logic len10;
    logic pd_en;
    logic baud_fast;
    logic [15:0] slot_delay;

    assign blank_sel = ctrl[`PSL_CTRL_BLANK];
    assign crc_sel = ctrl[`PSL_CTRL_CRC];
    assign len10 = ctrl[`PSL_CTRL_LEN10];
    assign pd_en = ctrl[`PSL_CTRL_PD];
    assign baud_fast = ctrl[`PSL_CTRL_BAUD];
    assign slot_delay = slot[15:0];

    // one wait state on every access
    assign avs_waitrequest = (avs_read || avs_write) && !ack;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            ack <= 1'b0;
        else
            ack <= (avs_read || avs_write) && !ack;
    end

    // writes land on the edge that completes the access, one edge after the wait drops
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            ctrl <= `PSL_CTRL_RST;
            slot <= `PSL_SLOT_RST;
            data <= `PSL_DATA_RST;
        end
        else if (avs_write && ack)
        begin
            case (avs_address)
                `PSL_REG_CTRL: ctrl <= merge(ctrl, avs_writedata, avs_byteenable) & 32'h0000_001F;
                `PSL_REG_SLOT: slot <= merge(slot, avs_writedata, avs_byteenable) & 32'h0000_FFFF;
                `PSL_REG_DATA: data <= merge(data, avs_writedata, avs_byteenable) & 32'h0000_03FF;
                default: ;
            endcase
        end
    end

    // read data captured one edge early so it stands when wait drops
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && !ack)
        begin
            case (avs_address)
                `PSL_REG_CTRL: avs_readdata <= ctrl;
                `PSL_REG_SLOT: avs_readdata <= slot;
                `PSL_REG_DATA: avs_readdata <= data;
                `PSL_REG_STAT: avs_readdata <= {12'h000, tx_busy, pd_on,
                    sd == SD_BLANK, sd == SD_QUAL, sync_count};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ***********************************
    // sync detection
    // ***********************************
    logic comp_m;
    logic comp_s;
    logic samp_en;
    logic [7:0] det_cnt;
    logic [17:0] ref_cnt;
    logic timing;
    logic synced;
    logic tx_sent;
    logic qual_end;
    logic [17:0] blank_len;
    logic [8:0] half_cyc;

    // pin enters through two flops before any logic
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            comp_m <= 1'b0;
            comp_s <= 1'b0;
        end
        else
        begin
            comp_m <= sync_comp_in;
            comp_s <= comp_m;
        end
    end

    // half-rate sample enable
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            samp_en <= 1'b0;
        else
            samp_en <= !samp_en;
    end

    assign half_cyc = baud_fast ? 9'(HALF190) : 9'(HALF125);
    assign qual_end = (sd == SD_QUAL) && (ref_cnt >= 18'(QUAL_CYC - 1));
    // blanking end, measured from the trip instant
    assign blank_len = blank_sel
        ? 18'(slot_delay) + 18'(frame_bits(len10, crc_sel)) * 18'({half_cyc, 1'b0})
        : 18'(OFF500_CYC);

    // sync time reference, restarted at the first trip
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            ref_cnt <= 18'h00000;
            timing <= 1'b0;
        end
        else if (sd == SD_IDLE && samp_en && comp_s)
        begin
            ref_cnt <= 18'h00000;
            timing <= 1'b1;
        end
        else if (qual_end && det_cnt <= 8'(MIN_CNT))
        begin
            ref_cnt <= 18'h00000;
            timing <= 1'b0;
        end
        else if (timing && ref_cnt != REF_MAX)
            ref_cnt <= ref_cnt + 18'h00001;
    end

    // qualify, then blank
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sd <= SD_IDLE;
            det_cnt <= 8'h00;
            sync_valid <= 1'b0;
        end
        else
        begin
            sync_valid <= 1'b0;
            case (sd)
                SD_IDLE:
                begin
                    if (samp_en && comp_s)
                    begin
                        sd <= SD_QUAL;
                        det_cnt <= 8'h01;
                    end
                end
                SD_QUAL:
                begin
                    if (qual_end)
                    begin
                        if (det_cnt > 8'(MIN_CNT))
                        begin
                            sd <= SD_BLANK;
                            sync_valid <= 1'b1;
                        end
                        else
                            sd <= SD_IDLE;
                        det_cnt <= 8'h00;
                    end
                    else if (samp_en && comp_s && det_cnt != 8'hFF)
                        det_cnt <= det_cnt + 8'h01;
                end
                SD_BLANK:
                begin
                    det_cnt <= 8'h00;
                    if (ref_cnt >= blank_len)
                        sd <= SD_IDLE;
                end
                default: sd <= SD_IDLE;
            endcase
        end
    end

    // response bookkeeping; synced clears at the next trip, the sync count never does
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            synced <= 1'b0;
            sync_count <= 16'h0000;
        end
        else if (sd == SD_IDLE && samp_en && comp_s)
            synced <= 1'b0;
        else if (sync_valid)
        begin
            synced <= 1'b1;
            sync_count <= sync_count + 16'h0001;
        end
    end

    // filter held from the valid pulse itself until the reset window has passed
    assign sync_filter_reset = (synced || sync_valid)
        && (ref_cnt < 18'(QUAL_CYC + FILT_CYC));

    // ***********************************
    // response frame
    // ***********************************
    psl_tx_if txi ();
    logic tx_load;

    // a slot delay shorter than qualification starts right after it
    assign tx_load = synced && !tx_sent && !tx_busy && ref_cnt >= 18'(slot_delay);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            tx_sent <= 1'b0;
        else if (sd == SD_IDLE && samp_en && comp_s)
            tx_sent <= 1'b0;
        else if (tx_load)
            tx_sent <= 1'b1;
    end

    assign txi.load = tx_load;
    assign txi.word = data[9:0];
    assign txi.len10 = len10;
    assign txi.crc_sel = crc_sel;
    assign txi.half_cyc = half_cyc;
    assign tx_busy = txi.busy;
    assign tx_level = txi.level;

    psl_frame_build u_build
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .txi(txi.builder)
    );

    psl_manch_tx u_tx
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .txi(txi.serial)
    );

    // ***********************************
    // current sink
    // ***********************************
    // pulldown shares the modulation sink with the frame
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            pd_on <= 1'b0;
        else
            pd_on <= pd_en && synced && ref_cnt >= 18'(PD_DLY_CYC)
                && ref_cnt < 18'(PD_DLY_CYC + PD_ON_CYC);
    end

    // sink enable only; the line voltage is never driven
    assign modulation_current = tx_level || pd_on;

    // ***********************************
    // checks
    // ***********************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    property p_samp_half;
        samp_en |=> !samp_en ##1 samp_en;
    endproperty
    a_samp_half: assert property (p_samp_half) else $error("sample rate not half");

    property p_trip_start;
        (sd == SD_IDLE && samp_en && comp_s) |=> (ref_cnt == 0 && sd == SD_QUAL && timing);
    endproperty
    a_trip_start: assert property (p_trip_start) else $error("trip did not start timers");

    property p_valid;
        (qual_end && det_cnt > MIN_CNT) |=> (sync_valid && sd == SD_BLANK) ##1 synced;
    endproperty
    a_valid: assert property (p_valid) else $error("valid sync not flagged");

    property p_fail;
        (qual_end && det_cnt <= MIN_CNT) |=> (sd == SD_IDLE && !timing && !sync_valid);
    endproperty
    a_fail: assert property (p_fail) else $error("failed sync did not re-arm");

    property p_blank_hold;
        (sd == SD_BLANK && ref_cnt < blank_len) |=> (sd == SD_BLANK && det_cnt == 0);
    endproperty
    a_blank_hold: assert property (p_blank_hold) else $error("blanking ended early");

    property p_blank_short;
        (sd == SD_BLANK && !blank_sel && $stable(ctrl) && ref_cnt == OFF500_CYC)
            |=> sd == SD_IDLE;
    endproperty
    a_blank_short: assert property (p_blank_short) else $error("short blank length wrong");

    property p_blank_var;
        (sd == SD_BLANK && blank_sel && $stable(ctrl) && $stable(slot)
            && ref_cnt == 18'(slot_delay) + 18'(2 + (len10 ? 10 : 8) + (crc_sel ? 3 : 1))
            * 18'(baud_fast ? 2 * HALF190 : 2 * HALF125)) |=> sd == SD_IDLE;
    endproperty
    a_blank_var: assert property (p_blank_var) else $error("variable blank length wrong");

    property p_filt;
        sync_valid |-> sync_filter_reset;
    endproperty
    a_filt: assert property (p_filt) else $error("filter not in reset at sync");

    property p_slot;
        tx_load |-> (ref_cnt >= slot_delay && synced) ##2 tx_busy;
    endproperty
    a_slot: assert property (p_slot) else $error("frame started before slot");

    property p_pd;
        (pd_en && synced && ref_cnt == PD_DLY_CYC) |=> modulation_current;
    endproperty
    a_pd: assert property (p_pd) else $error("pulldown not on");

    property p_quiet;
        (!tx_busy && !pd_on) |-> !modulation_current;
    endproperty
    a_quiet: assert property (p_quiet) else $error("current not idle");

    c_valid: cover property (sync_valid);
    c_fail: cover property (qual_end && det_cnt <= MIN_CNT);
    c_frame: cover property ($fell(tx_busy));
    c_pd: cover property ($rose(pd_on));
endmodule // psl_link

/* File: psl_manch_tx.sv */
module psl_manch_tx
(
    input wire logic sys_clk,
    input wire logic reset,
    psl_tx_if.serial txi
);
    import psl_pkg::*;

    psl_frame_t shift;
    logic [3:0] left;
    logic [8:0] half_cnt;
    logic phase;

    // half-bit timing from the system clock, level high means sink on
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            shift <= '0;
            left <= 4'h0;
            half_cnt <= 9'h000;
            phase <= 1'b0;
            txi.busy <= 1'b0;
            txi.level <= 1'b0;
        end
        else if (txi.start && !txi.busy)
        begin
            shift <= txi.frame;
            left <= txi.nbits;
            half_cnt <= 9'h000;
            phase <= 1'b0;
            txi.busy <= 1'b1;
            txi.level <= txi.frame[0];
        end
        else if (txi.busy)
        begin
            if (half_cnt == txi.half_cyc - 9'h001)
            begin
                half_cnt <= 9'h000;
                if (!phase)
                begin
                    phase <= 1'b1;
                    txi.level <= ~shift[0];
                end
                else if (left == 4'h1)
                begin
                    txi.busy <= 1'b0;
                    txi.level <= 1'b0;
                end
                else
                begin
                    // equal neighbours give a boundary edge by themselves
                    shift <= shift >> 1;
                    left <= left - 4'h1;
                    phase <= 1'b0;
                    txi.level <= shift[1];
                end
            end
            else
                half_cnt <= half_cnt + 9'h001;
        end
    end
endmodule // psl_manch_tx

/* File: psl_master_model.sv */
// ***********************************
// far-side controller: sync pulses out, frames in
// ***********************************
module psl_master_model
(
    input wire logic sys_clk,
    input wire logic modulation_current,
    output logic sync_comp_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // comparator rests low until the supply is raised
    initial sync_comp_in = 1'h0;

    // raise the supply for w clocks, changed just after an edge
    task automatic send_sync(input int w);
        sync_comp_in <= 1'h1;
        repeat (w) @(posedge sys_clk);
        sync_comp_in <= 1'h0;
    endtask

    // decode from the first mid edge; second half is the bit inverted
    task automatic get_frame(input int nb, input int h, output logic [14:0] bits,
        output logic bad);
        int n;
        logic fh;
        n = 0;
        bits = 15'h0000;
        bad = 1'h0;
        fh = 1'h0;
        // bounded wait, a missing frame is flagged not hung on
        while (modulation_current !== 1'h1 && n < 9000)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 9000) bad = 1'h1;
        repeat (h / 2) @(posedge sys_clk);
        for (int k = 0; k < nb; k++)
        begin
            if (k > 0 && modulation_current === fh) bad = 1'h1;
            bits[k] = ~modulation_current;
            repeat (h) @(posedge sys_clk);
            fh = modulation_current;
            repeat (h) @(posedge sys_clk);
        end
    endtask
endmodule // psl_master_model

/* File: psl_pkg.sv */
package psl_pkg;
    // sync detector phases
    typedef enum logic [1:0] {SD_IDLE, SD_QUAL, SD_BLANK} psl_sd_state_t;
    // frame bits, sent from bit 0 upward
    typedef logic [14:0] psl_frame_t;
endpackage

/* File: psl_tx_if.sv */
interface psl_tx_if;
    import psl_pkg::*;
    logic load;
    logic [9:0] word;
    logic len10;
    logic crc_sel;
    logic [8:0] half_cyc;
    psl_frame_t frame;
    logic [3:0] nbits;
    logic start;
    logic busy;
    logic level;
    modport ctrl (output load, word, len10, crc_sel, half_cyc, input busy, level);
    modport builder (input load, word, len10, crc_sel, output frame, nbits, start);
    modport serial (input frame, nbits, start, half_cyc, output busy, level);
endinterface

/* File: tb_psl_link.sv */
`include "psl_cfg.svh"
module tb_psl_link;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sync_comp_in;
    logic modulation_current;
    logic sync_valid;
    logic sync_filter_reset;
    int error_cnt = 0;
    int checks = 0;
    int vcnt = 0;
    int exp_v = 0;
    logic [31:0] q;

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    // short fixed blanking keeps runs brief
    psl_link #(.OFF500_CYC(600)) dut (.sys_clk(sys_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sync_comp_in(sync_comp_in), .modulation_current(modulation_current),
        .sync_valid(sync_valid), .sync_filter_reset(sync_filter_reset));

    psl_master_model master (.sys_clk(sys_clk), .modulation_current(modulation_current),
        .sync_comp_in(sync_comp_in));

    // count accepted sync pulses
    always @(posedge sys_clk)
        if (sync_valid === 1'h1) vcnt <= vcnt + 1;

    // ***********************************
    // shared tasks
    // ***********************************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // one access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'h0 && n < 50);
        q = avs_readdata;
        check("bus_done", 32'(n < 50), 32'h1);
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge sys_clk);
    endtask

    // pulse w clocks, judged 150 clocks after its start
    task automatic pulse(input int w, input int ev);
        master.send_sync(w);
        repeat (150 - w) @(posedge sys_clk);
        exp_v += ev;
        check("valid_cnt", 32'(vcnt), 32'(exp_v));
    endtask

    task automatic frame_chk(input int nb, input int h, input logic [14:0] exp);
        logic [14:0] bits;
        logic bad;
        master.get_frame(nb, h, bits, bad);
        check("frame", 32'(bits), 32'(exp));
        check("manchester", 32'(bad), 32'h0);
        check("idle", 32'(modulation_current), 32'h0);
    endtask

    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ***********************************
    // scenarios
    // ***********************************
    task automatic test_regs();
        bus(1'h0, `PSL_REG_CTRL, 32'h0);
        check("ctrl_rst", q, `PSL_CTRL_RST);
        bus(1'h0, `PSL_REG_SLOT, 32'h0);
        check("slot_rst", q, `PSL_SLOT_RST);
        bus(1'h1, 4'h1, 32'hFFFF_FFFF);
        bus(1'h0, 4'h1, 32'h0);
        check("unmapped", q, 32'h0);
        bus(1'h1, `PSL_REG_CTRL, 32'hFFFF_FFFF);
        bus(1'h0, `PSL_REG_CTRL, 32'h0);
        check("ctrl_mask", q, 32'h0000_001F);
        bus(1'h1, `PSL_REG_DATA, 32'hFFFF_FFFF);
        bus(1'h0, `PSL_REG_DATA, 32'h0);
        check("data_mask", q, 32'h0000_03FF);
        bus(1'h1, `PSL_REG_STAT, 32'hFFFF_FFFF);
        bus(1'h0, `PSL_REG_STAT, 32'h0);
        check("stat_ro", q, 32'h0);
    endtask

    // too-short pulse refused, the next one is taken; 8-bit crc frame
    task automatic test_reject();
        bus(1'h1, `PSL_REG_CTRL, 32'h0000_0002);
        bus(1'h1, `PSL_REG_SLOT, 32'h0000_00C8);
        bus(1'h1, `PSL_REG_DATA, 32'h0000_005A);
        pulse(60, 0);
        pulse(100, 1);
        frame_chk(13, 160, {2'h0, 3'b010, 8'h5A, 2'h0});
    endtask

    // pulldown window, filter reset, short blanking, 10-bit parity frame
    task automatic test_pulldown();
        bus(1'h1, `PSL_REG_CTRL, 32'h0000_000C);
        bus(1'h1, `PSL_REG_DATA, 32'h0000_00A7);
        bus(1'h1, `PSL_REG_SLOT, 32'h0000_0BB8);
        pulse(100, 1);
        repeat (50) @(posedge sys_clk);
        check("filt_on", 32'(sync_filter_reset), 32'h1);
        repeat (120) @(posedge sys_clk);
        check("filt_off", 32'(sync_filter_reset), 32'h0);
        repeat (60) @(posedge sys_clk);
        check("pd_on", 32'(modulation_current), 32'h1);
        pulse(100, 0);
        repeat (270) @(posedge sys_clk);
        check("pd_off", 32'(modulation_current), 32'h0);
        pulse(100, 1);
        repeat (700) @(posedge sys_clk);
        frame_chk(13, 160, {2'h0, ^10'h0A7, 10'h0A7, 2'h0});
    endtask

    // crc frames at the fast rate, pulse late in the long blanking
    task automatic test_crc();
        logic [9:0] dv [4] = '{10'h000, 10'h0CC, 10'h151, 10'h3FF};
        logic [2:0] cv [4] = '{3'h6, 3'h3, 3'h0, 3'h4};
        bus(1'h1, `PSL_REG_CTRL, 32'h0000_0017);
        bus(1'h1, `PSL_REG_SLOT, 32'h0000_00C8);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'h1, `PSL_REG_DATA, 32'(dv[i]));
            fork
                frame_chk(15, 105, {cv[i][0], cv[i][1], cv[i][2], dv[i], 2'h0});
                begin
                    pulse(100, 1);
                    repeat (3000) @(posedge sys_clk);
                    pulse(100, 0);
                end
            join
        end
        // status holds the running count of accepted syncs, all else idle
        bus(1'h0, `PSL_REG_STAT, 32'h0);
        check("stat_cnt", q, 32'(exp_v));
    endtask

    // watchdog, well past the expected run
    initial
    begin
        #(25 * 60000);
        error_cnt++;
        finish_test();
    end

    // main sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        @(posedge sys_clk);
        test_regs();
        test_reject();
        test_pulldown();
        test_crc();
        finish_test();
    end
endmodule // tb_psl_link
